// ==== dpr_defs.vh ====
`ifndef DPR_DEFS_VH
`define DPR_DEFS_VH

// register byte addresses
`define DPR_ADDR_CTRL 8'h00
`define DPR_ADDR_STATUS 8'h04
`define DPR_ADDR_POS 8'h08
`define DPR_ADDR_STSALM 8'h0c
`define DPR_ADDR_CMDPOS 8'h10
`define DPR_ADDR_FBPOS 8'h14
`define DPR_ADDR_ENC 8'h18
`define DPR_ADDR_MAX_POSITION_VALUE 8'h1c
`define DPR_ADDR_SCALE 8'h20
`define DPR_ADDR_IRQ_STAT 8'h24
`define DPR_ADDR_IRQ_MASK 8'h28
`define DPR_ADDR_MAP 8'h2c
`define DPR_ADDR_HOME 8'h30

// control register fields
`define DPR_CTRL_READ 0
`define DPR_CTRL_UPDATE 1
`define DPR_CTRL_SLC 2
`define DPR_CTRL_CURRENT 3

// status register fields
`define DPR_ST_READY 0
`define DPR_ST_BUSY 1
`define DPR_ST_POSITIVE_SOFT_LIMIT 2
`define DPR_ST_NEGATIVE_SOFT_LIMIT 3

// interrupt status fields
`define DPR_IRQ_DONE 0
`define DPR_IRQ_REJECT 1
`define DPR_IRQ_TIMEOUT 2
`define DPR_IRQ_W 3

// ready-flag map register: bit index and enable
`define DPR_MAP_EN 3

// reset values
`define DPR_MAX_POSITION_VALUE_RST 32'h7fffffff
`define DPR_SCALE_RST 16'h0001

// link frame: 32 position bits, 8 status, 8 alarm, two bits per strobe
`define DPR_FRAME_W 48
`define DPR_STROBES 6'h18
`define DPR_HALF_NS 1000
`define DPR_CLK_NS 10
`define DPR_HALF_CYC ((`DPR_HALF_NS + `DPR_CLK_NS - 1) / `DPR_CLK_NS)
`define DPR_TMO_MS 10
`define DPR_TMO_CYC (`DPR_TMO_MS * 1000000 / `DPR_CLK_NS)

`endif

// ==== dpr_link.v ====
`timescale 1ns/1ps
`default_nettype none
`include "dpr_defs.vh"

module dpr_link #(
   parameter TMO_CYC = `DPR_TMO_CYC
) (
   input wire clk_sys, // system clock
   input wire rst_n, // synchronised reset, active low
   input wire start, // one-cycle start of a fetch
   input wire drive_output_ready, // drive has data ready
   input wire serial_bit_lo, // serial data bit 0
   input wire serial_bit_hi, // serial data bit 1
   output reg transfer_demand, // transfer demand to drive
   output reg transfer_strobe, // transfer strobe to drive
   output reg done, // one-cycle frame complete
   output reg timeout, // one-cycle no-answer event
   output reg [`DPR_FRAME_W-1:0] frame // received frame, msb first
);
   localparam ST_IDLE = 2'd0;
   localparam ST_WAIT = 2'd1;
   localparam ST_HIGH = 2'd2;
   localparam ST_LOW = 2'd3;
   // counts are worked out as integers, then cut to the counter widths on purpose
   localparam integer HALF_I = `DPR_HALF_CYC - 1;
   localparam integer TMO_I = TMO_CYC - 1;
   localparam [7:0] HALF = HALF_I[7:0];
   localparam [23:0] TMO = TMO_I[23:0];

   reg [1:0] state_r;
   reg [7:0] half_r;
   reg [23:0] tmo_r;
   reg [5:0] cnt_r;

   // demand, wait for ready, then strobe two bits per pulse
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
         half_r <= 8'h00;
         tmo_r <= 24'h000000;
         cnt_r <= 6'h00;
         transfer_demand <= 1'b0;
         transfer_strobe <= 1'b0;
         done <= 1'b0;
         timeout <= 1'b0;
         frame <= {`DPR_FRAME_W{1'b0}};
      end else begin
         done <= 1'b0;
         timeout <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               if (start) begin
                  transfer_demand <= 1'b1;
                  tmo_r <= 24'h000000;
                  cnt_r <= 6'h00;
                  state_r <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               // a drive that never answers must not hang the block
               if (drive_output_ready) begin
                  transfer_strobe <= 1'b1;
                  half_r <= 8'h00;
                  state_r <= ST_HIGH;
               end else if (tmo_r == TMO) begin
                  transfer_demand <= 1'b0;
                  timeout <= 1'b1;
                  state_r <= ST_IDLE;
               end else begin
                  tmo_r <= tmo_r + 24'h000001;
               end
            end
            ST_HIGH: begin
               if (half_r == HALF) begin
                  // sample at the end of the high phase, data long settled
                  frame <= {frame[`DPR_FRAME_W-3:0], serial_bit_hi, serial_bit_lo};
                  transfer_strobe <= 1'b0;
                  half_r <= 8'h00;
                  cnt_r <= cnt_r + 6'h01;
                  state_r <= ST_LOW;
               end else begin
                  half_r <= half_r + 8'h01;
               end
            end
            ST_LOW: begin
               if (half_r == HALF) begin
                  half_r <= 8'h00;
                  if (cnt_r == `DPR_STROBES) begin
                     transfer_demand <= 1'b0;
                     done <= 1'b1;
                     state_r <= ST_IDLE;
                  end else begin
                     transfer_strobe <= 1'b1;
                     state_r <= ST_HIGH;
                  end
               end else begin
                  half_r <= half_r + 8'h01;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// ==== dpr_scale.v ====
`timescale 1ns/1ps
`default_nettype none

module dpr_scale (
   input wire [31:0] raw, // signed drive counts
   input wire [15:0] scale, // signed milli-units per count
   input wire [31:0] max_pos, // positive limit for written positions
   output reg [31:0] user_pos, // saturated user-unit value
   output reg [31:0] clamped // user_pos limited to +-max_pos
);
   reg signed [47:0] prod;
   reg signed [31:0] neg_max;

   // saturate to the 32-bit milli-unit range, then to the max setting
   always @* begin
      prod = $signed(raw) * $signed(scale);
      neg_max = -$signed(max_pos);
      if (prod > $signed(48'sh00007fffffff)) begin
         user_pos = 32'h7fffffff;
      end else if (prod < $signed(48'shffff80000000)) begin
         user_pos = 32'h80000000;
      end else begin
         user_pos = prod[31:0];
      end
      if ($signed(user_pos) > $signed(max_pos)) begin
         clamped = max_pos;
      end else if ($signed(user_pos) < neg_max) begin
         clamped = neg_max;
      end else begin
         clamped = user_pos;
      end
   end
endmodule
`default_nettype wire

// ==== dpr_top.v ====
`timescale 1ns/1ps
`default_nettype none
`include "dpr_defs.vh"

//Operation
// - read command fetches position, status code and alarm code from the drive
// - position scaled to user units stored; status and alarm stored together
// - update command overwrites commanded position, keeps feedback and encoder deviation
// - with soft limit control 1, update sets home and enables both limits
// - status word holds status byte above alarm byte
// - stored position and status word stay readable until next fetch
// - scaled position saturates to the signed 32-bit milli-unit range
// - commanded and home positions written by update are limited by the max position setting
// - read accepted whenever no fetch is busy, also during pulses; update during pulse generation is rejected with error
// - with current off commanded position tracks feedback with zero deviation
// - current command 0 removes torque and forces deviation zero
// - ready flag goes 1 once fetched data is stored
// - ready flag can be mapped onto a remote output bit
// - fetch uses demand, strobe, ready and two serial data bits
module dpr_top #(
   parameter TMO_CYC = `DPR_TMO_CYC
) (
   input wire clk_sys, // 100 mhz clock
   input wire resetn, // async reset, active low
   input wire [7:0] reg_addr, // register byte address
   input wire [31:0] reg_wdata, // write data
   input wire reg_wr, // write strobe
   input wire reg_rd, // read strobe
   output reg [31:0] reg_rdata_r, // read data, cycle after strobe
   input wire pulse_active, // pulse generation in progress
   input wire drive_output_ready, // drive ready input
   input wire serial_bit_lo, // serial bit 0 input
   input wire serial_bit_hi, // serial bit 1 input
   output wire transfer_demand, // demand output to drive
   output wire transfer_strobe, // strobe output to drive
   output reg position_data_ready_r, // fetched data available
   output reg [7:0] remote_out_r, // fieldbus remote output byte
   output reg current_on_r, // motor current enable
   output reg positive_soft_limit_r, // positive limit enabled
   output reg negative_soft_limit_r, // negative limit enabled
   output reg home_set_r, // one-cycle home established
   output reg irq_r // level interrupt
);
   reg rst_s1_r;
   reg rst_n_r;
   reg busy_r;
   reg update_r;
   reg slc_r;
   reg [31:0] drive_position_value_r;
   reg [15:0] drive_status_alarm_word_r;
   reg [31:0] commanded_position_r;
   reg [31:0] feedback_position_r;
   reg [31:0] encoder_count_r;
   reg [31:0] max_position_value_r;
   reg [15:0] scale_r;
   reg [31:0] home_position_r;
   reg [`DPR_IRQ_W-1:0] irq_stat_r;
   reg [`DPR_IRQ_W-1:0] irq_mask_r;
   reg [3:0] map_r;
   reg [31:0] rdata_nxt;
   reg [`DPR_IRQ_W-1:0] irq_set;
   wire link_done;
   wire link_tmo;
   wire [`DPR_FRAME_W-1:0] frame;
   wire [31:0] user_pos;
   wire [31:0] clamped;
   wire wr_ctrl;
   wire cmd_read;
   wire cmd_update;
   wire start;
   wire reject;

   // reset release through two flops
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rst_s1_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r <= rst_s1_r;
      end
   end

   // command decode; a command while busy is dropped
   assign wr_ctrl = reg_wr && (reg_addr == `DPR_ADDR_CTRL);
   assign cmd_read = wr_ctrl && reg_wdata[`DPR_CTRL_READ];
   assign cmd_update = wr_ctrl && reg_wdata[`DPR_CTRL_UPDATE];
   assign reject = cmd_update && pulse_active;
   assign start = !busy_r && ((cmd_update && !pulse_active) || (cmd_read && !cmd_update));

   dpr_link #(
      .TMO_CYC(TMO_CYC)
   ) u_link (
      .clk_sys(clk_sys),
      .rst_n(rst_n_r),
      .start(start),
      .drive_output_ready(drive_output_ready),
      .serial_bit_lo(serial_bit_lo),
      .serial_bit_hi(serial_bit_hi),
      .transfer_demand(transfer_demand),
      .transfer_strobe(transfer_strobe),
      .done(link_done),
      .timeout(link_tmo),
      .frame(frame)
   );

   dpr_scale u_scale (
      .raw(frame[`DPR_FRAME_W-1:16]),
      .scale(scale_r),
      .max_pos(max_position_value_r),
      .user_pos(user_pos),
      .clamped(clamped)
   );

   // fetch bookkeeping, stored results and ready flag
   always @(posedge clk_sys or negedge rst_n_r) begin
      if (!rst_n_r) begin
         busy_r <= 1'b0;
         update_r <= 1'b0;
         position_data_ready_r <= 1'b0;
         drive_position_value_r <= 32'h00000000;
         drive_status_alarm_word_r <= 16'h0000;
      end else begin
         if (start) begin
            busy_r <= 1'b1;
            update_r <= cmd_update;
            position_data_ready_r <= 1'b0;
         end else if (link_done) begin
            busy_r <= 1'b0;
            drive_position_value_r <= user_pos;
            drive_status_alarm_word_r <= frame[15:0];
            position_data_ready_r <= 1'b1;
         end else if (link_tmo) begin
            busy_r <= 1'b0;
         end
      end
   end

   // position registers: software writes, current-off tracking, update
   always @(posedge clk_sys or negedge rst_n_r) begin
      if (!rst_n_r) begin
         commanded_position_r <= 32'h00000000;
         feedback_position_r <= 32'h00000000;
         encoder_count_r <= 32'h00000000;
         home_position_r <= 32'h00000000;
         positive_soft_limit_r <= 1'b0;
         negative_soft_limit_r <= 1'b0;
         home_set_r <= 1'b0;
      end else begin
         home_set_r <= 1'b0;
         if (link_done && update_r) begin
            // deviations are taken before the overwrite so they survive it
            commanded_position_r <= clamped;
            feedback_position_r <= clamped + (feedback_position_r - commanded_position_r);
            encoder_count_r <= clamped + (encoder_count_r - commanded_position_r);
            if (slc_r) begin
               home_position_r <= clamped;
               home_set_r <= 1'b1;
               positive_soft_limit_r <= 1'b1;
               negative_soft_limit_r <= 1'b1;
            end
         end else begin
            if (reg_wr && (reg_addr == `DPR_ADDR_FBPOS)) begin
               feedback_position_r <= reg_wdata;
            end
            if (reg_wr && (reg_addr == `DPR_ADDR_ENC)) begin
               encoder_count_r <= reg_wdata;
            end
            if (!current_on_r) begin
               commanded_position_r <= feedback_position_r;
            end else if (reg_wr && (reg_addr == `DPR_ADDR_CMDPOS)) begin
               commanded_position_r <= reg_wdata;
            end
            if (reg_wr && (reg_addr == `DPR_ADDR_HOME)) begin
               positive_soft_limit_r <= reg_wdata[`DPR_ST_POSITIVE_SOFT_LIMIT];
               negative_soft_limit_r <= reg_wdata[`DPR_ST_NEGATIVE_SOFT_LIMIT];
            end
         end
      end
   end

   // software settings
   always @(posedge clk_sys or negedge rst_n_r) begin
      if (!rst_n_r) begin
         slc_r <= 1'b0;
         current_on_r <= 1'b0;
         max_position_value_r <= `DPR_MAX_POSITION_VALUE_RST;
         scale_r <= `DPR_SCALE_RST;
         irq_mask_r <= {`DPR_IRQ_W{1'b0}};
         map_r <= 4'h0;
      end else if (reg_wr) begin
         case (reg_addr)
            `DPR_ADDR_CTRL: begin
               slc_r <= reg_wdata[`DPR_CTRL_SLC];
               current_on_r <= reg_wdata[`DPR_CTRL_CURRENT];
            end
            `DPR_ADDR_MAX_POSITION_VALUE: max_position_value_r <= {1'b0, reg_wdata[30:0]};
            `DPR_ADDR_SCALE: scale_r <= reg_wdata[15:0];
            `DPR_ADDR_IRQ_MASK: irq_mask_r <= reg_wdata[`DPR_IRQ_W-1:0];
            `DPR_ADDR_MAP: map_r <= reg_wdata[3:0];
            default: ;
         endcase
      end
   end

   // ready flag onto the chosen remote output bit
   always @(posedge clk_sys or negedge rst_n_r) begin
      if (!rst_n_r) begin
         remote_out_r <= 8'h00;
      end else begin
         remote_out_r <= 8'h00;
         if (map_r[`DPR_MAP_EN]) begin
            remote_out_r[map_r[2:0]] <= position_data_ready_r;
         end
      end
   end

   // sticky events; a set in the clearing read cycle survives
   always @* begin
      irq_set = {`DPR_IRQ_W{1'b0}};
      irq_set[`DPR_IRQ_DONE] = link_done;
      irq_set[`DPR_IRQ_REJECT] = reject;
      irq_set[`DPR_IRQ_TIMEOUT] = link_tmo;
   end

   always @(posedge clk_sys or negedge rst_n_r) begin
      if (!rst_n_r) begin
         irq_stat_r <= {`DPR_IRQ_W{1'b0}};
         irq_r <= 1'b0;
      end else begin
         if (reg_rd && (reg_addr == `DPR_ADDR_IRQ_STAT)) begin
            irq_stat_r <= irq_set;
         end else begin
            irq_stat_r <= irq_stat_r | irq_set;
         end
         irq_r <= |((irq_stat_r | irq_set) & irq_mask_r &
                    ~({`DPR_IRQ_W{reg_rd && (reg_addr == `DPR_ADDR_IRQ_STAT)}} & ~irq_set));
      end
   end

   // read mux; unmapped addresses read zero
   always @* begin
      rdata_nxt = 32'h00000000;
      case (reg_addr)
         `DPR_ADDR_CTRL: begin
            rdata_nxt[`DPR_CTRL_SLC] = slc_r;
            rdata_nxt[`DPR_CTRL_CURRENT] = current_on_r;
         end
         `DPR_ADDR_STATUS: begin
            rdata_nxt[`DPR_ST_READY] = position_data_ready_r;
            rdata_nxt[`DPR_ST_BUSY] = busy_r;
            rdata_nxt[`DPR_ST_POSITIVE_SOFT_LIMIT] = positive_soft_limit_r;
            rdata_nxt[`DPR_ST_NEGATIVE_SOFT_LIMIT] = negative_soft_limit_r;
         end
         `DPR_ADDR_POS: rdata_nxt = drive_position_value_r;
         `DPR_ADDR_STSALM: rdata_nxt[15:0] = drive_status_alarm_word_r;
         `DPR_ADDR_CMDPOS: rdata_nxt = commanded_position_r;
         `DPR_ADDR_FBPOS: rdata_nxt = feedback_position_r;
         `DPR_ADDR_ENC: rdata_nxt = encoder_count_r;
         `DPR_ADDR_MAX_POSITION_VALUE: rdata_nxt = max_position_value_r;
         `DPR_ADDR_SCALE: rdata_nxt[15:0] = scale_r;
         `DPR_ADDR_IRQ_STAT: rdata_nxt[`DPR_IRQ_W-1:0] = irq_stat_r;
         `DPR_ADDR_IRQ_MASK: rdata_nxt[`DPR_IRQ_W-1:0] = irq_mask_r;
         `DPR_ADDR_MAP: rdata_nxt[3:0] = map_r;
         `DPR_ADDR_HOME: rdata_nxt = home_position_r;
         default: rdata_nxt = 32'h00000000;
      endcase
   end

   always @(posedge clk_sys or negedge rst_n_r) begin
      if (!rst_n_r) begin
         reg_rdata_r <= 32'h00000000;
      end else if (reg_rd) begin
         reg_rdata_r <= rdata_nxt;
      end else begin
         reg_rdata_r <= 32'h00000000;
      end
   end
endmodule
`default_nettype wire

// ==== dpr_drive_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module dpr_drive_model (
   input wire logic clk_sys, // system clock
   input wire logic transfer_demand, // demand from controller
   input wire logic transfer_strobe, // strobe from controller
   input wire logic [47:0] frame_in, // position, status, alarm
   input wire logic [7:0] answer_dly, // cycles to ready, 0 never answers
   output logic drive_output_ready, // ready to controller
   output logic serial_bit_lo, // data bit 0
   output logic serial_bit_hi // data bit 1
);
   logic [47:0] sh_r;
   logic [7:0] wait_r;
   logic strobe_d_r;

   initial begin
      drive_output_ready = 1'b0;
      serial_bit_lo = 1'b0;
      serial_bit_hi = 1'b1;
      strobe_d_r = 1'b0;
   end

   // idle lines toggle so a stale bit can never pass for data
   always @(posedge clk_sys) begin
      strobe_d_r <= transfer_strobe;
      if (!transfer_demand) begin
         drive_output_ready <= 1'b0;
         wait_r <= 8'h00;
         sh_r <= frame_in;
         serial_bit_lo <= ~serial_bit_lo;
         serial_bit_hi <= ~serial_bit_hi;
      end else begin
         if (answer_dly != 8'h00 && wait_r != answer_dly) begin
            wait_r <= wait_r + 8'h01;
         end else if (answer_dly != 8'h00) begin
            drive_output_ready <= 1'b1;
         end
         // two bits per strobe, msb first
         if (transfer_strobe && !strobe_d_r) begin
            {serial_bit_hi, serial_bit_lo} <= sh_r[47:46];
            sh_r <= {sh_r[45:0], 2'h0};
         end
      end
   end
endmodule

`default_nettype wire

// ==== dpr_top_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dpr_defs.vh"

module dpr_top_assertions #(
   parameter TMO_CYC = 50
) (
   input wire logic clk_sys, // clock
   input wire logic resetn, // async reset
   input wire logic [7:0] reg_addr, // address
   input wire logic [31:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic pulse_active, // pulse generation
   input wire logic drive_output_ready, // drive ready
   input wire logic transfer_demand, // demand
   input wire logic transfer_strobe, // strobe
   input wire logic position_data_ready_r, // ready flag
   input wire logic positive_soft_limit_r, // limit +
   input wire logic negative_soft_limit_r, // limit -
   input wire logic home_set_r // home pulse
);
   logic [7:0] hi_cnt_r;
   logic [31:0] wait_cnt_r;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   // strobe high length and wait for the drive's answer
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         hi_cnt_r <= 8'h00;
         wait_cnt_r <= 32'h0;
      end else begin
         hi_cnt_r <= transfer_strobe ? hi_cnt_r + 8'h01 : 8'h00;
         if (!transfer_demand) begin
            wait_cnt_r <= 32'h0;
         end else if (!drive_output_ready) begin
            wait_cnt_r <= wait_cnt_r + 32'h1;
         end
      end
   end

   demand_cause_a: assert property ($rose(transfer_demand) |->
      $past(reg_wr && reg_addr == `DPR_ADDR_CTRL && (reg_wdata[0] || reg_wdata[1])))
      else $error("demand without a fetch command");
   ready_clear_a: assert property ($rose(transfer_demand) |-> !position_data_ready_r)
      else $error("ready not cleared at fetch start");
   ready_hold_a: assert property ($fell(position_data_ready_r) |-> $rose(transfer_demand))
      else $error("ready dropped without a new fetch");
   ready_after_frame_a: assert property ($rose(position_data_ready_r) |-> !transfer_demand &&
      ($past(transfer_demand, 2) || $past(transfer_demand, 3)))
      else $error("ready rose outside frame end");
   update_reject_a: assert property (reg_wr && reg_addr == `DPR_ADDR_CTRL && reg_wdata[1] &&
      pulse_active && !transfer_demand |=> !transfer_demand [*2])
      else $error("update accepted during pulses");
   strobe_framed_a: assert property (transfer_strobe |-> transfer_demand)
      else $error("strobe outside demand");
   strobe_after_ready_a: assert property ($rose(transfer_strobe) |-> $past(drive_output_ready))
      else $error("strobe before drive ready");
   strobe_width_a: assert property ($fell(transfer_strobe) |-> hi_cnt_r == 8'h64)
      else $error("strobe high phase length wrong");
   answer_wait_a: assert property (wait_cnt_r <= TMO_CYC + 2)
      else $error("demand held past answer timeout");
   home_limits_a: assert property (home_set_r |-> ##[0:1] (positive_soft_limit_r &&
      negative_soft_limit_r))
      else $error("home set without both limits");
   home_pulse_a: assert property (home_set_r |=> !home_set_r)
      else $error("home pulse too long");
endmodule

bind dpr_top dpr_top_assertions #(.TMO_CYC(TMO_CYC)) dpr_top_assertions_i (
   .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .pulse_active(pulse_active), .drive_output_ready(drive_output_ready),
   .transfer_demand(transfer_demand), .transfer_strobe(transfer_strobe),
   .position_data_ready_r(position_data_ready_r), .positive_soft_limit_r(positive_soft_limit_r),
   .negative_soft_limit_r(negative_soft_limit_r), .home_set_r(home_set_r));

`default_nettype wire

// ==== test_dpr_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dpr_defs.vh"

module test_dpr_top;
   logic clk_sys, resetn, reg_wr, reg_rd, pulse_active;
   logic [7:0] reg_addr, remote_out_r, answer_dly;
   logic [31:0] reg_wdata, reg_rdata_r;
   logic [47:0] frame_in;
   wire drv_rdy, bit_lo, bit_hi, transfer_demand, transfer_strobe;
   wire position_data_ready_r, current_on_r, lim_p, lim_n, home_set_r, irq_r;
   int errors = 0;
   int checks_done = 0;

   dpr_top #(.TMO_CYC(50)) dpr_top_i (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
      .pulse_active(pulse_active), .drive_output_ready(drv_rdy), .serial_bit_lo(bit_lo),
      .serial_bit_hi(bit_hi), .transfer_demand(transfer_demand), .transfer_strobe(transfer_strobe),
      .position_data_ready_r(position_data_ready_r), .remote_out_r(remote_out_r),
      .current_on_r(current_on_r), .positive_soft_limit_r(lim_p), .negative_soft_limit_r(lim_n),
      .home_set_r(home_set_r), .irq_r(irq_r));

   dpr_drive_model dpr_drive_model_i (.clk_sys(clk_sys), .transfer_demand(transfer_demand),
      .transfer_strobe(transfer_strobe), .frame_in(frame_in), .answer_dly(answer_dly),
      .drive_output_ready(drv_rdy), .serial_bit_lo(bit_lo), .serial_bit_hi(bit_hi));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic conclude();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one-cycle strobes, an idle cycle after each so no signal is set twice at an edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata_r;
      @(posedge clk_sys);
      chk(d, e);
   endtask

   // command, then wait for the frame or the timeout to finish
   task automatic fetch(input logic [47:0] f, input logic [31:0] c);
      frame_in <= f;
      wr(`DPR_ADDR_CTRL, c);
      chk({31'h0, position_data_ready_r}, 32'h0);
      repeat (6000) if (transfer_demand === 1'b1) @(posedge clk_sys);
      chk({31'h0, transfer_demand}, 32'h0);
      repeat (3) @(posedge clk_sys);
   endtask

   initial begin
      repeat (60000) @(posedge clk_sys);
      errors++;
      conclude();
   end

   initial begin
      resetn <= 1'b0;
      {reg_wr, reg_rd, pulse_active, reg_addr, reg_wdata} <= '0;
      frame_in <= 48'h0;
      answer_dly <= 8'h05;
      repeat (6) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rc(`DPR_ADDR_MAX_POSITION_VALUE, `DPR_MAX_POSITION_VALUE_RST);
      rc(`DPR_ADDR_SCALE, 32'h1);
      rc(`DPR_ADDR_STATUS, 32'h0);
      rc(8'hfc, 32'h0);
      wr(`DPR_ADDR_IRQ_MASK, 32'h7);
      wr(`DPR_ADDR_MAP, 32'hd);
      // plain read, prompt drive
      answer_dly <= 8'h01;
      fetch({32'h64, 8'h1c, 8'h48}, 32'h1);
      rc(`DPR_ADDR_POS, 32'h64);
      rc(`DPR_ADDR_STSALM, 32'h1c48);
      chk({31'h0, position_data_ready_r}, 32'h1);
      chk({24'h0, remote_out_r}, 32'h20);
      chk({31'h0, irq_r}, 32'h1);
      rc(`DPR_ADDR_IRQ_STAT, 32'h1);
      @(posedge clk_sys);
      chk({31'h0, irq_r}, 32'h0);
      // read during pulses, slow drive, negative scaled value
      wr(`DPR_ADDR_SCALE, 32'h3);
      pulse_active <= 1'b1;
      answer_dly <= 8'h28;
      fetch({32'hfffffffb, 8'h01, 8'h02}, 32'h1);
      rc(`DPR_ADDR_POS, 32'hfffffff1);
      rc(`DPR_ADDR_STSALM, 32'h0102);
      // update refused during pulses, masked interrupt
      wr(`DPR_ADDR_IRQ_MASK, 32'h0);
      wr(`DPR_ADDR_CTRL, 32'h2);
      repeat (3) @(posedge clk_sys);
      chk({31'h0, transfer_demand}, 32'h0);
      chk({31'h0, irq_r}, 32'h0);
      rc(`DPR_ADDR_IRQ_STAT, 32'h3);
      rc(`DPR_ADDR_POS, 32'hfffffff1);
      pulse_active <= 1'b0;
      wr(`DPR_ADDR_IRQ_MASK, 32'h7);
      // saturation at both ends
      answer_dly <= 8'h05;
      wr(`DPR_ADDR_SCALE, 32'h2);
      fetch({32'h7fffffff, 16'h0}, 32'h1);
      rc(`DPR_ADDR_POS, 32'h7fffffff);
      fetch({32'h80000000, 16'h0}, 32'h1);
      rc(`DPR_ADDR_POS, 32'h80000000);
      // update with current off, clamped by max position
      wr(`DPR_ADDR_SCALE, 32'h1);
      wr(`DPR_ADDR_MAX_POSITION_VALUE, 32'h3e8);
      fetch({32'h1388, 16'h0}, 32'h2);
      rc(`DPR_ADDR_POS, 32'h1388);
      rc(`DPR_ADDR_CMDPOS, 32'h3e8);
      rc(`DPR_ADDR_FBPOS, 32'h3e8);
      rc(`DPR_ADDR_ENC, 32'h3e8);
      // update with current on and soft limits, deviation of 0x3b6 kept
      wr(`DPR_ADDR_MAX_POSITION_VALUE, 32'h7fffffff);
      wr(`DPR_ADDR_CTRL, 32'h8);
      chk({31'h0, current_on_r}, 32'h1);
      wr(`DPR_ADDR_CMDPOS, 32'h32);
      fetch({32'hc8, 16'h0}, 32'he);
      rc(`DPR_ADDR_CMDPOS, 32'hc8);
      rc(`DPR_ADDR_FBPOS, 32'h47e);
      rc(`DPR_ADDR_ENC, 32'h47e);
      chk({30'h0, lim_p, lim_n}, 32'h3);
      rc(`DPR_ADDR_STATUS, 32'hd);
      // drive never answers
      answer_dly <= 8'h00;
      fetch({32'h1, 16'h0}, 32'h1);
      chk({31'h0, position_data_ready_r}, 32'h0);
      chk({24'h0, remote_out_r}, 32'h0);
      rc(`DPR_ADDR_IRQ_STAT, 32'h5);
      rc(`DPR_ADDR_POS, 32'hc8);
      conclude();
   end
endmodule

`default_nettype wire
